/* core/bcs_pkg.sv */
package bcs_pkg;
  // oscillator-cycle limits
  localparam int PRECHG_LIMIT = 32768;
  localparam int TOTAL_LIMIT = 262144;
  localparam int TIMER_W = 19;
  localparam int SYNC_STAGES = 2;
  localparam int FLAG_W = 8;
  // flag vector bit positions
  localparam int F_VIN_LOW = 0;
  localparam int F_VIN_HIGH = 1;
  localparam int F_VIN_BELOW_BAT = 2;
  localparam int F_BAT_ABOVE_PRE = 3;
  localparam int F_BAT_AT_REG = 4;
  localparam int F_CUR_AT_FULL = 5;
  localparam int F_BAT_AT_RECHG = 6;
  localparam int F_THERM_BAD = 7;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;

  typedef enum logic [5:0] {
    BCS_IDLE = 6'b00_0001,
    BCS_PRE = 6'b00_0010,
    BCS_CC = 6'b00_0100,
    BCS_CV = 6'b00_1000,
    BCS_FULL = 6'b01_0000,
    BCS_FAULT = 6'b10_0000
  } bcs_state_t;
endpackage : bcs_pkg

/* core/bcs_flag_sync.sv */
module bcs_flag_sync
  import bcs_pkg::*;
#(
  parameter int WIDTH = FLAG_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] flags_async,
  output logic [WIDTH-1:0] flags_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage1 = flags_async;
    next_sync = stage1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= WIDTH'(FLAGS_RESET);
      flags_sync <= WIDTH'(FLAGS_RESET);
    end else begin
      stage1 <= next_stage1;
      flags_sync <= next_sync;
    end
  end
endmodule : bcs_flag_sync

/* core/bcs_timer.sv */
module bcs_timer
  import bcs_pkg::*;
#(
  parameter int WIDTH = TIMER_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic run,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] next_count;

  // saturating up counter
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (run && count != {WIDTH{1'b1}}) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule : bcs_timer

/* core/bcs_sequencer.sv */
// What this block does
// - charging stops while input is below 3.0 V or above 7.0 V.
// - power good pulled low only while input sits inside its window.
// - charging stops while input is below battery voltage.
// - start below 2.6 V enters precharge at one tenth current.
// - precharge over 32768 cycles ends charging with a battery fault.
// - battery above 2.6 V in time moves to full constant current.
// - battery at 4.2 V moves to constant voltage until full.
// - current at or below 20 percent in constant voltage means full, charger off.
// - after full, battery at 4.0 V restarts charging.
// - total time over 262144 cycles without full gives timeout fault.
// - timeout fault toggles status at half oscillator rate.
// - after fault stay off until power cycle or shutdown toggle.
// - charge timer restarts from zero at power-up and each enable.
// - timer disable input suppresses both time limits.
// - charging ceases while thermistor window reports bad temperature.
// - status low while charging, released on full and on stops other than timeout fault.
module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter int PRE_CYCLES = PRECHG_LIMIT,
  parameter int TOTAL_CYCLES = TOTAL_LIMIT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shutdown_in,
  input wire logic timer_disable,
  input wire logic vin_low,
  input wire logic vin_high,
  input wire logic vin_below_bat,
  input wire logic bat_above_pre,
  input wire logic bat_at_reg,
  input wire logic cur_at_full,
  input wire logic bat_at_rechg,
  input wire logic therm_bad,
  output logic charge_en,
  output logic precharge_current,
  output logic constant_current_phase,
  output logic constant_voltage_phase,
  output logic timeout_fault,
  output logic battery_fault,
  output logic power_good_n_o,
  output logic power_good_n_oe,
  output logic charge_status_n_o,
  output logic charge_status_n_oe
);
  import bcs_pkg::*;

  localparam logic [TIMER_W-1:0] PRE_MAX = TIMER_W'(PRE_CYCLES);
  localparam logic [TIMER_W-1:0] TOT_MAX = TIMER_W'(TOTAL_CYCLES);

  ////////////////////////////////////////////////////////////////////////
  logic [FLAG_W-1:0] raw_flags;
  logic [FLAG_W-1:0] flags;
  logic [TIMER_W-1:0] pre_count;
  logic [TIMER_W-1:0] tot_count;

  assign raw_flags = {therm_bad, bat_at_rechg, cur_at_full, bat_at_reg,
                      bat_above_pre, vin_below_bat, vin_high, vin_low};

  bcs_flag_sync #(.WIDTH(FLAG_W)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .flags_async(raw_flags),
    .flags_sync(flags)
  );

  ////////////////////////////////////////////////////////////////////////
  logic vin_ok;
  logic sd;
  logic blocked;
  bcs_state_t state;
  bcs_state_t next_state;
  logic enabled;
  logic next_enabled;
  logic toggle;
  logic next_toggle;
  logic is_timeout;
  logic next_is_timeout;
  logic in_charge;

  assign vin_ok = !flags[F_VIN_LOW] && !flags[F_VIN_HIGH];
  assign sd = shutdown_in;
  // shutdown, input window, input below battery, temperature
  assign blocked = sd || !vin_ok || flags[F_VIN_BELOW_BAT] || flags[F_THERM_BAD];
  assign in_charge = (state == BCS_PRE) || (state == BCS_CC) || (state == BCS_CV);

  // timers: total restarts on enable transition, precharge clears whenever state is not BCS_PRE
  bcs_timer #(.WIDTH(TIMER_W)) u_pre_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(state != BCS_PRE),
    .run(state == BCS_PRE),
    .count(pre_count)
  );

  bcs_timer #(.WIDTH(TIMER_W)) u_tot_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(sd || (!enabled && !sd)),
    .run(in_charge && !blocked),
    .count(tot_count)
  );

  always_comb begin
    next_state = state;
    next_enabled = !sd;
    next_is_timeout = is_timeout;
    next_toggle = 1'b0;
    if (sd) begin
      next_state = BCS_IDLE;
      next_is_timeout = 1'b0;
    end else begin
      unique case (state)
        BCS_IDLE: begin
          if (!blocked) begin
            next_state = flags[F_BAT_ABOVE_PRE] ? BCS_CC : BCS_PRE;
          end
        end
        BCS_PRE: begin
          if (!timer_disable && pre_count >= PRE_MAX) begin
            next_state = BCS_FAULT;
            next_is_timeout = 1'b0;
          end else if (flags[F_BAT_ABOVE_PRE]) begin
            next_state = BCS_CC;
          end
        end
        BCS_CC: begin
          if (flags[F_BAT_AT_REG]) begin
            next_state = BCS_CV;
          end
        end
        BCS_CV: begin
          if (flags[F_CUR_AT_FULL]) begin
            next_state = BCS_FULL;
          end
        end
        BCS_FULL: begin
          if (flags[F_BAT_AT_RECHG] && !blocked) begin
            next_state = BCS_CC;
          end
        end
        BCS_FAULT: begin
          next_state = BCS_FAULT;
        end
      endcase
      if ((state == BCS_CC || state == BCS_CV) && !timer_disable
          && tot_count >= TOT_MAX) begin
        next_state = BCS_FAULT;
        next_is_timeout = 1'b1;
      end
      if (state == BCS_FAULT && is_timeout) begin
        next_toggle = !toggle;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= BCS_IDLE;
      enabled <= 1'b0;
      is_timeout <= 1'b0;
      toggle <= 1'b0;
    end else begin
      state <= next_state;
      enabled <= next_enabled;
      is_timeout <= next_is_timeout;
      toggle <= next_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic next_charge_en;
  logic next_pre_cur;
  logic next_cc;
  logic next_cv;
  logic next_pg_oe;
  logic next_chg_oe;
  logic next_timeout_fault;
  logic next_battery_fault;

  always_comb begin
    next_charge_en = in_charge && !blocked;
    next_pre_cur = state == BCS_PRE;
    next_cc = state == BCS_CC;
    next_cv = state == BCS_CV;
    next_pg_oe = vin_ok;
    next_chg_oe = 1'b0;
    next_timeout_fault = state == BCS_FAULT && is_timeout;
    next_battery_fault = state == BCS_FAULT && !is_timeout;
    if (in_charge && !blocked) begin
      next_chg_oe = 1'b1;
    end else if (state == BCS_FAULT && is_timeout && !sd && vin_ok) begin
      next_chg_oe = toggle;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      charge_en <= 1'b0;
      precharge_current <= 1'b0;
      constant_current_phase <= 1'b0;
      constant_voltage_phase <= 1'b0;
      power_good_n_oe <= 1'b0;
      charge_status_n_oe <= 1'b0;
      timeout_fault <= 1'b0;
      battery_fault <= 1'b0;
    end else begin
      charge_en <= next_charge_en;
      precharge_current <= next_pre_cur;
      constant_current_phase <= next_cc;
      constant_voltage_phase <= next_cv;
      power_good_n_oe <= next_pg_oe;
      charge_status_n_oe <= next_chg_oe;
      timeout_fault <= next_timeout_fault;
      battery_fault <= next_battery_fault;
    end
  end

  assign power_good_n_o = 1'b0;
  assign charge_status_n_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // input window and blocking conditions
  a_pg_window: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> power_good_n_oe == $past(vin_ok))
    else $error("power good mismatch");
  a_block_vin: assert property (@(posedge clk) disable iff (sys_rst)
    !vin_ok |=> !charge_en)
    else $error("charging with bad input");
  a_block_below: assert property (@(posedge clk) disable iff (sys_rst)
    flags[F_VIN_BELOW_BAT] |=> !charge_en)
    else $error("charging below battery");
  a_block_therm: assert property (@(posedge clk) disable iff (sys_rst)
    flags[F_THERM_BAD] |=> !charge_en)
    else $error("charging at bad temp");
  a_vin_release: assert property (@(posedge clk) disable iff (sys_rst)
    !vin_ok |=> !charge_status_n_oe)
    else $error("status driven with bad input");

  // flags reach the sequencer two edges after the pins
  a_sync_delay: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(sys_rst, 2) |-> flags == $past(raw_flags, 2))
    else $error("flag sync latency wrong");

  // phase sequencing
  a_pre_entry: assert property (@(posedge clk) disable iff (sys_rst)
    !sys_rst && state == BCS_IDLE && !blocked && !flags[F_BAT_ABOVE_PRE] |=> state == BCS_PRE)
    else $error("precharge not entered");
  a_pre_outputs: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_PRE && !blocked |=> charge_en && precharge_current)
    else $error("precharge current not requested");
  a_pre_limit: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_PRE && !timer_disable && pre_count >= PRE_MAX && !sd
    |=> state == BCS_FAULT && !is_timeout)
    else $error("precharge limit missed");
  a_cc_entry: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_PRE && flags[F_BAT_ABOVE_PRE] && !sd && (timer_disable || pre_count < PRE_MAX)
    |=> state == BCS_CC) else $error("cc not entered");
  a_cc_phase: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_CC |=> constant_current_phase && !precharge_current)
    else $error("cc phase output wrong");
  a_cc_cv: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_CC && flags[F_BAT_AT_REG] && !sd && !(tot_count >= TOT_MAX && !timer_disable)
    |=> state == BCS_CV) else $error("cv not entered");
  a_cv_phase: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_CV |=> constant_voltage_phase && !constant_current_phase)
    else $error("cv phase output wrong");
  a_cv_full: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_CV && flags[F_CUR_AT_FULL] && !sd && !(tot_count >= TOT_MAX && !timer_disable)
    |=> state == BCS_FULL) else $error("full not declared");
  a_full_off: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_FULL |=> !charge_en)
    else $error("charging after full");
  a_rechg_start: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_FULL && flags[F_BAT_AT_RECHG] && !blocked |=> state == BCS_CC)
    else $error("recharge not started");

  // time limits and faults
  a_timeout_entry: assert property (@(posedge clk) disable iff (sys_rst)
    (state == BCS_CC || state == BCS_CV) && !timer_disable && tot_count >= TOT_MAX && !sd
    |=> state == BCS_FAULT && is_timeout) else $error("total limit missed");
  a_timer_off: assert property (@(posedge clk) disable iff (sys_rst)
    timer_disable && state != BCS_FAULT |=> state != BCS_FAULT)
    else $error("fault with timer disabled");
  a_timer_restart: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(enabled) |-> tot_count == '0)
    else $error("timer not restarted on enable");
  a_fault_hold: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_FAULT && !sd |=> state == BCS_FAULT)
    else $error("fault left early");
  a_toggle_rate: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_FAULT && is_timeout && !sd ##1 state == BCS_FAULT && !sd
    |-> toggle != $past(toggle)) else $error("timeout not toggling");

  // status pin
  a_status_on: assert property (@(posedge clk) disable iff (sys_rst)
    in_charge && !blocked |=> charge_status_n_oe)
    else $error("status not low while charging");
  a_status_off: assert property (@(posedge clk) disable iff (sys_rst)
    state == BCS_FULL || (state == BCS_FAULT && !is_timeout) |=> !charge_status_n_oe)
    else $error("status driven when not charging");
  a_sd_release: assert property (@(posedge clk) disable iff (sys_rst)
    sd |=> !charge_status_n_oe)
    else $error("status driven in shutdown");
endmodule : bcs_sequencer

/* verification/bcs_status_reader.sv */
module bcs_status_reader (
  input wire logic power_good_n_o,
  input wire logic power_good_n_oe,
  input wire logic charge_status_n_o,
  input wire logic charge_status_n_oe,
  output logic power_good_pin,
  output logic charge_status_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-ups on both open-drain lines
  assign power_good_pin = power_good_n_oe ? power_good_n_o : 1'b1;
  assign charge_status_pin = charge_status_n_oe ? charge_status_n_o : 1'b1;
endmodule : bcs_status_reader

/* verification/battery_charge_sequencer_test.sv */
module battery_charge_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bcs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic shutdown_in = 1'b0;
  logic timer_disable = 1'b1;
  logic [FLAG_W-1:0] flags = 8'h00;
  logic charge_en, precharge_current, cc_ph, cv_ph, timeout_fault, battery_fault;
  logic pg_o, pg_oe, st_o, st_oe, pg_pin, st_pin, st0;
  int fails = 0;
  int tests_run = 0;
  int blk [4];
  wire [3:0] obs = {charge_en, precharge_current, pg_pin, st_pin};

  bcs_sequencer #(.PRE_CYCLES(16), .TOTAL_CYCLES(64)) bcs_sequencer_i (
    .clk(clk), .sys_rst(sys_rst), .shutdown_in(shutdown_in), .timer_disable(timer_disable),
    .vin_low(flags[F_VIN_LOW]), .vin_high(flags[F_VIN_HIGH]),
    .vin_below_bat(flags[F_VIN_BELOW_BAT]), .bat_above_pre(flags[F_BAT_ABOVE_PRE]),
    .bat_at_reg(flags[F_BAT_AT_REG]), .cur_at_full(flags[F_CUR_AT_FULL]),
    .bat_at_rechg(flags[F_BAT_AT_RECHG]), .therm_bad(flags[F_THERM_BAD]),
    .charge_en(charge_en), .precharge_current(precharge_current),
    .constant_current_phase(cc_ph), .constant_voltage_phase(cv_ph),
    .timeout_fault(timeout_fault), .battery_fault(battery_fault),
    .power_good_n_o(pg_o), .power_good_n_oe(pg_oe),
    .charge_status_n_o(st_o), .charge_status_n_oe(st_oe)
  );
  bcs_status_reader bcs_status_reader_i (
    .power_good_n_o(pg_o), .power_good_n_oe(pg_oe), .charge_status_n_o(st_o),
    .charge_status_n_oe(st_oe), .power_good_pin(pg_pin), .charge_status_pin(st_pin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic set_flag(input int idx, input logic v);
    @(posedge clk);
    flags[idx] <= v;
  endtask : set_flag

  // shutdown low again after a high pulse
  task automatic toggle_shutdown();
    @(posedge clk);
    shutdown_in <= 1'b1;
    settle(6);
    check({charge_en, st_pin}, 2'b01);
    @(posedge clk);
    shutdown_in <= 1'b0;
  endtask : toggle_shutdown

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #80000;
    fails++;
    tally_and_finish();
  end

  initial begin
    blk = '{F_VIN_LOW, F_VIN_HIGH, F_VIN_BELOW_BAT, F_THERM_BAD};
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    settle(6);
    check(obs, 4'b1100);
    for (int i = 0; i < 4; i++) begin
      set_flag(blk[i], 1'b1);
      settle(6);
      check({charge_en, pg_pin, st_pin}, {1'b0, i < 2, 1'b1});
      set_flag(blk[i], 1'b0);
      settle(6);
      check(obs, 4'b1100);
    end
    settle(30);
    check({battery_fault, charge_en}, 2'b01);
    $display("test blocking done");
    set_flag(F_BAT_ABOVE_PRE, 1'b1);
    settle(6);
    check({obs, cc_ph, cv_ph}, 6'b100010);
    set_flag(F_BAT_AT_REG, 1'b1);
    settle(6);
    check({charge_en, cc_ph, cv_ph}, 3'b101);
    set_flag(F_CUR_AT_FULL, 1'b1);
    settle(6);
    check({charge_en, st_pin}, 2'b01);
    set_flag(F_CUR_AT_FULL, 1'b0);
    set_flag(F_BAT_AT_REG, 1'b0);
    set_flag(F_BAT_AT_RECHG, 1'b1);
    settle(6);
    check({charge_en, st_pin, cc_ph}, 3'b101);
    set_flag(F_BAT_AT_RECHG, 1'b0);
    $display("test charge cycle done");
    @(posedge clk);
    timer_disable <= 1'b0;
    set_flag(F_BAT_ABOVE_PRE, 1'b0);
    toggle_shutdown();
    settle(8);
    check({battery_fault, charge_en, precharge_current}, 3'b011);
    settle(32);
    check({battery_fault, charge_en, st_pin}, 3'b101);
    set_flag(F_BAT_ABOVE_PRE, 1'b1);
    settle(20);
    check({battery_fault, charge_en}, 2'b10);
    toggle_shutdown();
    settle(6);
    check({battery_fault, charge_en, cc_ph}, 3'b011);
    $display("test precharge fault done");
    settle(50);
    check({timeout_fault, charge_en, cc_ph}, 3'b011);
    settle(40);
    check({timeout_fault, charge_en}, 2'b10);
    st0 = st_pin;
    settle(1);
    check(st0 ^ st_pin, 1'b1);
    set_flag(F_VIN_LOW, 1'b1);
    settle(6);
    st0 = st_pin;
    settle(1);
    check({st0, st_pin, pg_pin, timeout_fault}, 4'b1111);
    $display("test timeout done");
    tally_and_finish();
  end
endmodule : battery_charge_sequencer_test
